/* File: src/tpr_regs.svh */
`ifndef TPR_REGS_SVH
`define TPR_REGS_SVH

// Register byte offsets on the AHB-Lite slave
`define TPR_OFF_CTRL 12'h000
`define TPR_OFF_STAT 12'h004
`define TPR_OFF_IRQ_STAT 12'h008
`define TPR_OFF_IRQ_MASK 12'h00C
`define TPR_OFF_PT1 12'h010
`define TPR_OFF_PT2 12'h014
`define TPR_OFF_SETUP_LO 12'h018
`define TPR_OFF_SETUP_HI 12'h01C
`define TPR_OFF_DATA_LO 12'h020
`define TPR_OFF_DATA_HI 12'h024
`define TPR_OFF_RPT_LO 12'h028
`define TPR_OFF_RPT_HI 12'h02C
`define TPR_OFF_CMD 12'h030

// Report identifiers
`define TPR_ID_DRIVER 8'h02
`define TPR_ID_UTILITY 8'h07

// Request header values
`define TPR_RT_SET 8'h21
`define TPR_RT_GET 8'hA1
`define TPR_REQ_SET 8'h09
`define TPR_REQ_GET 8'h01
`define TPR_VAL_FEATURE 8'h03
`define TPR_FID_CMD 8'h03
`define TPR_FID_STATUS 8'h06
`define TPR_LEN_CMD 16'h0008
`define TPR_IDX_ZERO 16'h0000

// Command subtypes
`define TPR_SUB_ASYNC 8'h05
`define TPR_SUB_CAL 8'h04
`define TPR_SUB_RESET 8'h07
`define TPR_SUB_DEFAULTS 8'h08

// Async report selector codes
`define TPR_SEL_OFF 8'h00
`define TPR_SEL_ON 8'h01
`define TPR_SEL_HID 8'h02
`define TPR_SEL_PACKED 8'h03
`define TPR_SEL_UTILITY 8'h06
`define TPR_SEL_RESTORE 8'h07

// Interrupt bit positions and status width
`define TPR_IRQ_RPT 0
`define TPR_IRQ_CMD 1
`define TPR_IRQ_STALL 2
`define TPR_IRQ_W 3

`endif

/* File: src/tpr_pkg.sv */
package tpr_pkg;

  typedef struct packed
  {
    logic touch;
    logic [11:0] x;
    logic [11:0] y;
  } tpr_point_t;

  typedef struct packed
  {
    logic [7:0] req_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } tpr_setup_t;

  typedef enum logic [2:0]
  {
    TPR_MODE_OFF,
    TPR_MODE_HID,
    TPR_MODE_PACKED,
    TPR_MODE_UTILITY
  } tpr_mode_t;

  typedef enum logic [2:0]
  {
    TPR_CMD_NONE,
    TPR_CMD_ASYNC,
    TPR_CMD_CAL,
    TPR_CMD_RESET,
    TPR_CMD_DEFAULTS,
    TPR_CMD_STATUS
  } tpr_cmd_t;

endpackage

/* File: src/tpr_packer.sv */
`timescale 1ns/1ps
`include "tpr_regs.svh"

module tpr_packer
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Points in
  input wire logic sample_vld,
  input wire logic utility,
  input wire tpr_pkg::tpr_point_t pt1,
  input wire tpr_pkg::tpr_point_t pt2,
  input wire logic pt2_valid,
  // Report out
  output logic [63:0] report_r,
  output logic report_vld_r
);

  logic [3:0] st1;
  logic [3:0] st2;

  // Unused status bits forced to zero
  assign st1 = {2'b00, 1'b1, pt1.touch};
  assign st2 = {2'b00, pt2_valid, pt2_valid & pt2.touch};

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      report_r <= 64'h0000000000000000;
      report_vld_r <= 1'b0;
    end
    else
    begin
      report_vld_r <= sample_vld;
      if (sample_vld)
      begin
        report_r[7:0] <= utility ? `TPR_ID_UTILITY : `TPR_ID_DRIVER;
        report_r[15:8] <= {pt1.x[3:0], st1};
        report_r[23:16] <= pt1.x[11:4];
        report_r[31:24] <= pt1.y[7:0];
        report_r[39:32] <= {st2, pt1.y[11:8]};
        report_r[47:40] <= pt2.x[7:0];
        report_r[55:48] <= {pt2.y[3:0], pt2.x[11:8]};
        report_r[63:56] <= pt2.y[11:4];
      end
    end
  end

  chk_status_unused: assert property (@(posedge core_clk) disable iff (rst)
    report_vld_r |-> (report_r[11:10] == 2'b00 && report_r[39:38] == 2'b00))
    else $error("unused status bits not zero");
  chk_first_valid: assert property (@(posedge core_clk) disable iff (rst)
    report_vld_r |-> report_r[9])
    else $error("first sub-report not valid");
  chk_byte_two: assert property (@(posedge core_clk) disable iff (rst)
    sample_vld |=> report_r[23:16] == $past(pt1.x[11:4]))
    else $error("byte two wrong");
  chk_byte_six: assert property (@(posedge core_clk) disable iff (rst)
    sample_vld |=> report_r[55:48] == {$past(pt2.y[3:0]), $past(pt2.x[11:8])})
    else $error("byte six wrong");

endmodule

/* File: src/tpr_top.sv */
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tpr_regs.svh"

// Operation
// - Packed report sent per new sample only while packed type active; also sent in utility mode here.
// - Report opens with id 0x02 for driver, 0x07 for utility.
// - Two sub-reports, each status nibble plus 12-bit X and Y, packed.
// - First sub-report always valid; only second may be invalid.
// - Byte1 = X1[3:0] and status1; byte2 = X1[11:4].
// - Byte3 = Y1[7:0]; byte4 = status2 and Y1[11:8].
// - Byte5 X2[7:0]; byte6 Y2[3:0],X2[11:8]; byte7 Y2[11:4].
// - Status bit0 touching, bit1 valid, bits 2 and 3 meaningless.
// - Commands are HID Get/Set Feature requests sharing feature ids.
// - Set 0x21/0x09 id 0x03 subtypes 05,04,07,08; status 0xA1/0x01 id 0x06.
// - Malformed, forbidden or unsupported commands fail.
// - Unprocessable feature request stalls the control endpoint.
// - One async report type active; one-point type after reset.
module tpr_top
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Touch samples
  input wire logic sample_vld,
  input wire tpr_pkg::tpr_point_t pt1,
  input wire tpr_pkg::tpr_point_t pt2,
  input wire logic pt2_valid,
  // Report stream
  output logic [63:0] report_r,
  output logic report_vld_r,
  // Control endpoint
  output logic ep0_stall_r,
  output logic cmd_ok_r,
  output logic cal_start_r,
  output logic soft_reset_r,
  output logic defaults_r,
  output logic status_rd_r,
  // Interrupt
  output logic irq_r
);

  tpr_pkg::tpr_mode_t mode_r;
  tpr_pkg::tpr_mode_t prev_mode_r;
  tpr_pkg::tpr_setup_t setup_r;
  logic [63:0] data_r;
  logic [`TPR_IRQ_W-1:0] irq_stat_r;
  logic [`TPR_IRQ_W-1:0] irq_mask_r;
  logic [`TPR_IRQ_W-1:0] irq_ev;
  logic [7:0] last_sel_r;
  logic cmd_fail_r;
  logic dp_wr_r;
  logic dp_rd_r;
  logic [11:0] dp_addr_r;
  logic cmd_go;
  logic pk_sample;
  logic pk_utility;
  logic [63:0] pk_report;
  logic pk_vld;
  tpr_pkg::tpr_cmd_t dec_cmd;
  logic dec_ok;
  logic sel_ok;

  // Request classification, shared by execution and status
  function automatic tpr_pkg::tpr_cmd_t decode(input tpr_pkg::tpr_setup_t s,
                                               input logic [7:0] fid,
                                               input logic [7:0] sub);
    tpr_pkg::tpr_cmd_t c;
    c = tpr_pkg::TPR_CMD_NONE;
    // Header checks; any mismatch is malformed
    if (s.value[15:8] == `TPR_VAL_FEATURE && s.index == `TPR_IDX_ZERO &&
        s.length == `TPR_LEN_CMD)
    begin
      if (s.req_type == `TPR_RT_SET && s.request == `TPR_REQ_SET &&
          s.value[7:0] == `TPR_FID_CMD && fid == `TPR_FID_CMD)
      begin
        case (sub)
          `TPR_SUB_ASYNC: c = tpr_pkg::TPR_CMD_ASYNC;
          `TPR_SUB_CAL: c = tpr_pkg::TPR_CMD_CAL;
          `TPR_SUB_RESET: c = tpr_pkg::TPR_CMD_RESET;
          `TPR_SUB_DEFAULTS: c = tpr_pkg::TPR_CMD_DEFAULTS;
          default: c = tpr_pkg::TPR_CMD_NONE;
        endcase
      end
      else if (s.req_type == `TPR_RT_GET && s.request == `TPR_REQ_GET &&
               s.value[7:0] == `TPR_FID_STATUS)
        c = tpr_pkg::TPR_CMD_STATUS;
    end
    return c;
  endfunction

  assign dec_cmd = decode(setup_r, data_r[7:0], data_r[15:8]);
  // Selector must be a known code; utility may not be reentered
  assign sel_ok = (data_r[39:32] == `TPR_SEL_OFF) || (data_r[39:32] == `TPR_SEL_ON) ||
                  (data_r[39:32] == `TPR_SEL_HID) || (data_r[39:32] == `TPR_SEL_PACKED) ||
                  (data_r[39:32] == `TPR_SEL_UTILITY && mode_r != tpr_pkg::TPR_MODE_UTILITY) ||
                  (data_r[39:32] == `TPR_SEL_RESTORE && mode_r == tpr_pkg::TPR_MODE_UTILITY);
  assign dec_ok = (dec_cmd != tpr_pkg::TPR_CMD_NONE) &&
                  (dec_cmd != tpr_pkg::TPR_CMD_ASYNC || sel_ok);
  assign cmd_go = dp_wr_r && dp_addr_r == `TPR_OFF_CMD && hwdata[0];

  // AHB address phase capture
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_addr_r <= 12'h000;
    end
    else if (hready)
    begin
      dp_wr_r <= hsel && htrans[1] && hwrite;
      dp_rd_r <= hsel && htrans[1] && !hwrite;
      dp_addr_r <= haddr[11:0];
    end
  end

  // Zero-wait, always OKAY
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read mux; registered so hrdata stands a cycle after the address phase
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr[11:0])
        `TPR_OFF_CTRL: hrdata <= {24'h000000, last_sel_r};
        `TPR_OFF_STAT: hrdata <= {24'h000000, cmd_fail_r, 1'b0, prev_mode_r, 1'b0, mode_r[1:0]};
        `TPR_OFF_IRQ_STAT: hrdata <= {29'h0000000, irq_stat_r};
        `TPR_OFF_IRQ_MASK: hrdata <= {29'h0000000, irq_mask_r};
        `TPR_OFF_SETUP_LO: hrdata <= {setup_r.value, setup_r.request, setup_r.req_type};
        `TPR_OFF_SETUP_HI: hrdata <= {setup_r.length, setup_r.index};
        `TPR_OFF_DATA_LO: hrdata <= data_r[31:0];
        `TPR_OFF_DATA_HI: hrdata <= data_r[63:32];
        `TPR_OFF_RPT_LO: hrdata <= report_r[31:0];
        `TPR_OFF_RPT_HI: hrdata <= report_r[63:32];
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Setup and data-stage staging written by the endpoint firmware
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      setup_r <= '0;
      data_r <= 64'h0000000000000000;
    end
    else if (dp_wr_r)
    begin
      case (dp_addr_r)
        `TPR_OFF_SETUP_LO: {setup_r.value, setup_r.request, setup_r.req_type} <= hwdata;
        `TPR_OFF_SETUP_HI: {setup_r.length, setup_r.index} <= hwdata;
        `TPR_OFF_DATA_LO: data_r[31:0] <= hwdata;
        `TPR_OFF_DATA_HI: data_r[63:32] <= hwdata;
        default: data_r <= data_r;
      endcase
    end
  end

  // Report type; single active mode, one-point after reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= tpr_pkg::TPR_MODE_HID;
      prev_mode_r <= tpr_pkg::TPR_MODE_HID;
      last_sel_r <= `TPR_SEL_HID;
    end
    else if (cmd_go && dec_ok)
    begin
      if (dec_cmd == tpr_pkg::TPR_CMD_RESET || dec_cmd == tpr_pkg::TPR_CMD_DEFAULTS)
      begin
        mode_r <= tpr_pkg::TPR_MODE_HID;
        prev_mode_r <= tpr_pkg::TPR_MODE_HID;
        last_sel_r <= `TPR_SEL_HID;
      end
      else if (dec_cmd == tpr_pkg::TPR_CMD_ASYNC)
      begin
        last_sel_r <= data_r[39:32];
        case (data_r[39:32])
          `TPR_SEL_OFF: mode_r <= tpr_pkg::TPR_MODE_OFF;
          `TPR_SEL_ON: mode_r <= prev_mode_r;
          `TPR_SEL_HID:
          begin
            mode_r <= tpr_pkg::TPR_MODE_HID;
            prev_mode_r <= tpr_pkg::TPR_MODE_HID;
          end
          `TPR_SEL_PACKED:
          begin
            mode_r <= tpr_pkg::TPR_MODE_PACKED;
            prev_mode_r <= tpr_pkg::TPR_MODE_PACKED;
          end
          `TPR_SEL_UTILITY: mode_r <= tpr_pkg::TPR_MODE_UTILITY;
          `TPR_SEL_RESTORE: mode_r <= prev_mode_r;
          default: mode_r <= mode_r;
        endcase
      end
    end
  end

  // Command outcome pulses; a failure stalls endpoint 0
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ep0_stall_r <= 1'b0;
      cmd_ok_r <= 1'b0;
      cal_start_r <= 1'b0;
      soft_reset_r <= 1'b0;
      defaults_r <= 1'b0;
      status_rd_r <= 1'b0;
      cmd_fail_r <= 1'b0;
    end
    else
    begin
      ep0_stall_r <= cmd_go && !dec_ok;
      cmd_ok_r <= cmd_go && dec_ok;
      cal_start_r <= cmd_go && dec_ok && dec_cmd == tpr_pkg::TPR_CMD_CAL;
      soft_reset_r <= cmd_go && dec_ok && dec_cmd == tpr_pkg::TPR_CMD_RESET;
      defaults_r <= cmd_go && dec_ok && dec_cmd == tpr_pkg::TPR_CMD_DEFAULTS;
      status_rd_r <= cmd_go && dec_ok && dec_cmd == tpr_pkg::TPR_CMD_STATUS;
      if (cmd_go)
        cmd_fail_r <= !dec_ok;
    end
  end

  // Packed reports only in packed or utility mode
  assign pk_sample = sample_vld &&
                     (mode_r == tpr_pkg::TPR_MODE_PACKED || mode_r == tpr_pkg::TPR_MODE_UTILITY);
  assign pk_utility = (mode_r == tpr_pkg::TPR_MODE_UTILITY);

  tpr_packer u_packer
  (
    .core_clk(core_clk),
    .rst(rst),
    .sample_vld(pk_sample),
    .utility(pk_utility),
    .pt1(pt1),
    .pt2(pt2),
    .pt2_valid(pt2_valid),
    .report_r(pk_report),
    .report_vld_r(pk_vld)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      report_r <= 64'h0000000000000000;
      report_vld_r <= 1'b0;
    end
    else
    begin
      report_r <= pk_report;
      report_vld_r <= pk_vld;
    end
  end

  // Interrupts; set wins over write-one-to-clear
  assign irq_ev = {ep0_stall_r, cmd_ok_r, report_vld_r};

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end
    else
    begin
      if (dp_wr_r && dp_addr_r == `TPR_OFF_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~hwdata[`TPR_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_r <= irq_stat_r | irq_ev;
      if (dp_wr_r && dp_addr_r == `TPR_OFF_IRQ_MASK)
        irq_mask_r <= hwdata[`TPR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  chk_no_report_idle: assert property (@(posedge core_clk) disable iff (rst)
    (sample_vld && mode_r == tpr_pkg::TPR_MODE_HID) |-> ##2 !report_vld_r)
    else $error("packed report sent while not active");
  chk_report_follows: assert property (@(posedge core_clk) disable iff (rst)
    (sample_vld && mode_r == tpr_pkg::TPR_MODE_PACKED) |-> ##2 report_vld_r)
    else $error("packed report missing");
  chk_report_id: assert property (@(posedge core_clk) disable iff (rst)
    report_vld_r |-> (report_r[7:0] == `TPR_ID_DRIVER || report_r[7:0] == `TPR_ID_UTILITY))
    else $error("bad report id");
  chk_bad_stalls: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_go && !dec_ok) |=> (ep0_stall_r && !cmd_ok_r))
    else $error("bad command not stalled");
  chk_wrong_len: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_go && setup_r.length != `TPR_LEN_CMD) |=> ep0_stall_r)
    else $error("malformed length accepted");
  chk_reset_mode: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_go && dec_cmd == tpr_pkg::TPR_CMD_RESET) |=> mode_r == tpr_pkg::TPR_MODE_HID)
    else $error("reset did not restore one-point mode");
  chk_async_decode: assert property (@(posedge core_clk) disable iff (rst)
    (setup_r.req_type == `TPR_RT_SET && setup_r.request == `TPR_REQ_SET &&
     setup_r.value == {`TPR_VAL_FEATURE, `TPR_FID_CMD} && setup_r.index == `TPR_IDX_ZERO &&
     setup_r.length == `TPR_LEN_CMD && data_r[15:0] == {`TPR_SUB_ASYNC, `TPR_FID_CMD}) |->
     dec_cmd == tpr_pkg::TPR_CMD_ASYNC)
    else $error("async select not decoded");
  // A stall must stay visible to firmware even if a clear lands in the same cycle
  chk_stall_sticky: assert property (@(posedge core_clk) disable iff (rst)
    ep0_stall_r |=> irq_stat_r[`TPR_IRQ_STALL])
    else $error("stall event lost from status");

endmodule

/* File: bench/tpr_host_model.sv */
`timescale 1ns/1ps
`include "tpr_regs.svh"

module tpr_host_model
(
  // Clock
  input wire logic core_clk,
  // AHB-Lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'hA5A5A5A5;
  end

  // Single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
    // Released data bus must not keep looking valid
    hwdata <= ~d;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // Stage header and data stage, then launch the request
  task automatic request(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] v,
                         input logic [15:0] idx, input logic [15:0] len,
                         input logic [63:0] d);
    wr(`TPR_OFF_SETUP_LO, {v, rq, rt});
    wr(`TPR_OFF_SETUP_HI, {len, idx});
    wr(`TPR_OFF_DATA_LO, d[31:0]);
    wr(`TPR_OFF_DATA_HI, d[63:32]);
    wr(`TPR_OFF_CMD, 32'h1);
  endtask
endmodule

/* File: bench/tb_tpr_top.sv */
`timescale 1ns/1ps
`include "tpr_regs.svh"

module tb_tpr_top;
  localparam logic [6:0] P_RPT = 7'h40;
  localparam logic [6:0] P_STALL = 7'h20;
  localparam logic [6:0] P_OK = 7'h10;
  localparam logic [6:0] P_CAL = 7'h08;
  localparam logic [6:0] P_RST = 7'h04;
  localparam logic [6:0] P_DEF = 7'h02;
  localparam logic [6:0] P_STS = 7'h01;
  logic core_clk, rst, hsel, hwrite, hreadyout, hresp, sample_vld, pt2_valid;
  logic [31:0] haddr, hwdata, hrdata, q, q2;
  logic [1:0] htrans;
  logic [2:0] hsize;
  tpr_pkg::tpr_point_t pt1, pt2;
  logic [63:0] report_r, last_rpt;
  logic report_vld_r, ep0_stall_r, cmd_ok_r, cal_start_r, soft_reset_r, defaults_r;
  logic status_rd_r, irq_r;
  logic [6:0] pv;
  int cnt [7];
  int base [7];
  int fail_count, comparisons;

  tpr_top dut(.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_vld(sample_vld), .pt1(pt1), .pt2(pt2),
    .pt2_valid(pt2_valid), .report_r(report_r), .report_vld_r(report_vld_r),
    .ep0_stall_r(ep0_stall_r), .cmd_ok_r(cmd_ok_r), .cal_start_r(cal_start_r),
    .soft_reset_r(soft_reset_r), .defaults_r(defaults_r), .status_rd_r(status_rd_r),
    .irq_r(irq_r));

  tpr_host_model host(.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // One-cycle pulses are counted so a task can judge them after the fact
  assign pv = {report_vld_r, ep0_stall_r, cmd_ok_r, cal_start_r, soft_reset_r, defaults_r,
               status_rd_r};
  always @(posedge core_clk)
  begin
    for (int i = 0; i < 7; i++)
      if (pv[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    if (report_vld_r === 1'b1) last_rpt <= report_r;
  end

  function automatic logic [6:0] hits();
    logic [6:0] h;
    for (int i = 0; i < 7; i++) h[i] = (cnt[i] != base[i]);
    return h;
  endfunction

  function automatic logic [63:0] dat(input logic [7:0] sub, input logic [7:0] s);
    return {24'h0, s, 16'h0, sub, `TPR_FID_CMD};
  endfunction

  function automatic logic [63:0] rpt(input logic [7:0] id, input tpr_pkg::tpr_point_t a,
                                      input tpr_pkg::tpr_point_t b, input logic v);
    logic [3:0] s1, s2;
    s1 = {2'b00, 1'b1, a.touch};
    s2 = {2'b00, v, b.touch & v};
    return {b.y[11:4], b.y[3:0], b.x[11:8], b.x[7:0], s2, a.y[11:8], a.y[7:0],
            a.x[11:4], a.x[3:0], s1, id};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] v,
                     input logic [15:0] idx, input logic [15:0] len, input logic [63:0] d,
                     input logic [6:0] exp);
    base = cnt;
    host.request(rt, rq, v, idx, len, d);
    repeat (4) @(posedge core_clk);
    check(hits(), exp);
  endtask

  task automatic sel(input logic [7:0] s, input logic [6:0] exp);
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0303, 16'h0, 16'h8, dat(`TPR_SUB_ASYNC, s), exp);
  endtask

  // Sends one sample; id of zero means no report may appear
  task automatic sample(input tpr_pkg::tpr_point_t a, input tpr_pkg::tpr_point_t b,
                        input logic v, input logic [7:0] id);
    base = cnt;
    @(posedge core_clk);
    sample_vld <= 1'b1;
    pt1 <= a;
    pt2 <= b;
    pt2_valid <= v;
    @(posedge core_clk);
    sample_vld <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(hits(), (id == 8'h0) ? 7'h0 : P_RPT);
    if (id != 8'h0) check(last_rpt, rpt(id, a, b, v));
  endtask

  task automatic t_reset();
    check({hreadyout, hresp, irq_r, report_vld_r, ep0_stall_r}, 5'h10);
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0303, 16'h0, 16'h8, dat(`TPR_SUB_RESET, 8'h0), P_OK | P_RST);
    sample({1'b1, 12'h123, 12'h456}, {1'b1, 12'h789, 12'hABC}, 1'b1, 8'h0);
  endtask

  task automatic t_packed();
    sel(`TPR_SEL_PACKED, P_OK);
    sample({1'b1, 12'hFFF, 12'h000}, {1'b1, 12'h5A3, 12'hC3E}, 1'b1, `TPR_ID_DRIVER);
    sample({1'b0, 12'h9C1, 12'h7E2}, {1'b1, 12'hFFF, 12'hFFF}, 1'b0, `TPR_ID_DRIVER);
    host.rd(`TPR_OFF_RPT_LO, q);
    host.rd(`TPR_OFF_RPT_HI, q2);
    check({q2, q}, rpt(`TPR_ID_DRIVER, {1'b0, 12'h9C1, 12'h7E2}, {1'b1, 12'hFFF, 12'hFFF}, 1'b0));
  endtask

  task automatic t_modes();
    sel(`TPR_SEL_UTILITY, P_OK);
    sample({1'b1, 12'h0F0, 12'hF0F}, {1'b0, 12'h321, 12'h654}, 1'b1, `TPR_ID_UTILITY);
    sel(`TPR_SEL_UTILITY, P_STALL);
    host.rd(`TPR_OFF_STAT, q);
    host.rd(`TPR_OFF_CTRL, q2);
    check({q2, q}, {32'h00000006, 32'h00000093});
    sel(`TPR_SEL_RESTORE, P_OK);
    sample({1'b1, 12'h001, 12'h800}, {1'b1, 12'h010, 12'h100}, 1'b1, `TPR_ID_DRIVER);
    sel(`TPR_SEL_OFF, P_OK);
    sample({1'b1, 12'h111, 12'h222}, {1'b1, 12'h333, 12'h444}, 1'b1, 8'h0);
  endtask

  task automatic t_cmds();
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0303, 16'h0, 16'h8, dat(`TPR_SUB_CAL, 8'h1), P_OK | P_CAL);
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0303, 16'h0, 16'h8, dat(`TPR_SUB_DEFAULTS, 8'h0), P_OK | P_DEF);
    cmd(`TPR_RT_GET, `TPR_REQ_GET, 16'h0306, 16'h0, 16'h8, 64'h0, P_OK | P_STS);
  endtask

  task automatic t_fail();
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0303, 16'h0, 16'h8, dat(8'h09, 8'h0), P_STALL);
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0303, 16'h1, 16'h8, dat(`TPR_SUB_CAL, 8'h1), P_STALL);
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0303, 16'h0, 16'h10, dat(`TPR_SUB_CAL, 8'h1), P_STALL);
    cmd(`TPR_RT_SET, `TPR_REQ_SET, 16'h0203, 16'h0, 16'h8, dat(`TPR_SUB_CAL, 8'h1), P_STALL);
    cmd(`TPR_RT_GET, `TPR_REQ_SET, 16'h0303, 16'h0, 16'h8, dat(`TPR_SUB_CAL, 8'h1), P_STALL);
    sel(8'h04, P_STALL);
  endtask

  task automatic t_irq();
    host.rd(`TPR_OFF_IRQ_STAT, q);
    check({31'h0, q, irq_r}, {31'h0, 32'h7, 1'b0});
    host.wr(`TPR_OFF_IRQ_MASK, 32'h4);
    repeat (2) @(posedge core_clk);
    check({63'h0, irq_r}, 64'h1);
    host.wr(`TPR_OFF_IRQ_STAT, 32'h7);
    repeat (2) @(posedge core_clk);
    host.rd(`TPR_OFF_IRQ_STAT, q);
    check({31'h0, q, irq_r}, 64'h0);
    host.rd(12'h100, q);
    check({32'h0, q}, 64'h0);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, failures %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    sample_vld = 1'b0;
    pt2_valid = 1'b0;
    pt1 = '0;
    pt2 = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_packed();
    t_modes();
    t_cmds();
    t_fail();
    t_irq();
    print_verdict();
  end
endmodule
